// File: hw/i2m_top.sv
// two-wire bus controller: clock sync, arbitration, slave receive and reply
// assumes open-drain pads outside; scl_in/sda_in are asynchronous pins
//
// What this block does
// R01 - released clock freezes baud counter until high
// R02 - clock seen high reloads counter, counting resumes
// R03 - counter steps twice per cycle, rollover toggles clock
// R04 - clock release sampled once per instruction cycle
// R05 - clock low at rollover holds the counter
// R06 - after hold, rollover follows then toggles clock
// R07 - released data read low means collision
// R08 - collision sets status bit ten, master interrupt
// R09 - collision returns master to idle
// R10 - arbitration checked in every master event
// R11 - collision in byte: stop, clear full flag
// R12 - collision in event: abort, clear request bits
// R13 - software checks collision, restarts whole message
// R14 - software confirms idle bus before start
// R15 - lost start raises collision interrupt
// R16 - lost repeated start raises collision interrupt
// R17 - lost stop raises collision interrupt
// R18 - sync and arbitration always on, no setting
// R19 - start sets start-seen; stop sets stop-seen
// R20 - slave only answers, never begins transfers
// R21 - slave address seven or ten bits
// R22 - address match raises slave interrupt
// R23 - slave receive: ack, buffer byte, interrupt
// R24 - software loads reply byte for slave reads
// R25 - slave samples bits on clock rise
// R26 - open-drain drive, compare data while clock high
`timescale 1ns/100ps

module i2m_fifo #(
    parameter int WIDTH = i2m_pkg::DATA_W,
    parameter int DEPTH = i2m_pkg::FIFO_DEPTH
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    // pointers wrap naturally, so depth must be a power of two
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0]    wp;
        logic [AW-1:0]    rp;
        logic [AW:0]      cnt;
        logic             ov;
        logic [WIDTH-1:0] od;
    } i2m_fifo_state_t;

    i2m_fifo_state_t  q;
    i2m_fifo_state_t  next_q;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = q.cnt != (AW+1)'(DEPTH);
    assign push      = in_valid && in_ready;
    assign out_valid = q.ov;
    assign out_data  = q.od;

    always_comb begin
        next_q = q;
        pop = 1'b0;
        if (push) begin
            next_q.wp = q.wp + 1'b1;
        end
        // output stage refills from memory whenever it is free or drained
        if (!q.ov || out_ready) begin
            if (q.cnt != '0) begin
                next_q.od = mem[q.rp];
                next_q.ov = 1'b1;
                next_q.rp = q.rp + 1'b1;
                pop = 1'b1;
            end else begin
                next_q.ov = 1'b0;
            end
        end
        if (push && !pop) begin
            next_q.cnt = q.cnt + 1'b1;
        end else if (!push && pop) begin
            next_q.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[q.wp] <= in_data;
        end
    end
endmodule // i2m_fifo

module i2m_top (
    input  wire logic                          ref_clk,
    input  wire logic                          rst,
    input  wire logic                          enable,
    input  wire logic                          ten_bit_mode,
    input  wire logic [9:0]                    own_address,
    input  wire logic [i2m_pkg::BAUD_W-1:0]    baud_reload_value,
    input  wire i2m_pkg::i2m_ctrl_t            cmd,
    input  wire logic                          ack_data,
    input  wire logic                          tx_write,
    input  wire logic [7:0]                    tx_data,
    input  wire logic                          collision_clear,
    input  wire logic                          scl_in,
    input  wire logic                          sda_in,
    output logic                               scl_out,
    output logic                               scl_oe,
    output logic                               sda_out,
    output logic                               sda_oe,
    output i2m_pkg::i2m_ctrl_t                 bus_control_register,
    output logic [15:0]                        bus_status_register,
    output logic                               master_irq,
    output logic                               slave_irq,
    output logic                               rx_valid,
    output logic [7:0]                         rx_data,
    input  wire logic                          rx_ready
);
    i2m_pkg::i2m_top_state_t q;
    i2m_pkg::i2m_top_state_t next_q;
    logic                    fifo_ready;
    logic                    scl_hi;
    logic                    sda_hi;
    logic                    tick;
    logic                    coll;
    logic                    done;
    logic                    scl_rise;
    logic                    scl_fall;

    assign scl_hi = q.scl_s2;
    assign sda_hi = q.sda_s2;
    assign scl_rise = scl_hi && !q.scl_p;
    assign scl_fall = !scl_hi && q.scl_p;

    // pins only ever pull low; the enables carry the drive
    assign scl_out = 1'b0; // R26
    assign sda_out = 1'b0; // R26
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign bus_control_register = q.ctrl;
    assign master_irq = q.m_irq;
    assign slave_irq = q.s_irq;

    always_comb begin
        bus_status_register = '0;
        bus_status_register[i2m_pkg::STAT_TBF] = q.st.transmit_full_flag;
        bus_status_register[i2m_pkg::STAT_RSEL] = q.st.read_sel;
        bus_status_register[i2m_pkg::STAT_START] = q.st.start_seen;
        bus_status_register[i2m_pkg::STAT_STOP] = q.st.stop_seen;
        bus_status_register[i2m_pkg::STAT_A10] = q.st.addr10;
        bus_status_register[i2m_pkg::STAT_BCL] = q.st.bus_collision_flag; // R08
        bus_status_register[i2m_pkg::STAT_ACKST] = q.st.ack_status;
    end

    always_comb begin
        next_q = q;
        tick = 1'b0;
        coll = 1'b0;
        done = 1'b0;
        next_q.m_irq = 1'b0;
        next_q.s_irq = 1'b0;
        next_q.scl_s1 = scl_in;
        next_q.scl_s2 = q.scl_s1;
        next_q.scl_p = q.scl_s2;
        next_q.sda_s1 = sda_in;
        next_q.sda_s2 = q.sda_s1;
        next_q.sda_p = q.sda_s2;
        next_q.tcy = ~q.tcy;

        // baud counter; clock sync runs in every master event, no mode bit
        if (q.m == i2m_pkg::M_IDLE) begin
            next_q.baud = baud_reload_value;
            next_q.hold_hi = 1'b0;
        end else if (!q.m_scl && !scl_hi) begin
            next_q.hold_hi = 1'b1; // R01 R05 R18
        end else if (q.hold_hi) begin
            if (q.tcy) begin
                next_q.baud = baud_reload_value; // R02 R04
                next_q.hold_hi = 1'b0;
            end
        end else if (q.baud == '0) begin
            tick = 1'b1; // R03 R06
            next_q.baud = baud_reload_value;
        end else begin
            next_q.baud = q.baud - 1'b1; // R03
        end

        // writes while the buffer is full are dropped
        if (tx_write && !q.st.transmit_full_flag) begin
            next_q.txb = tx_data;
            next_q.st.transmit_full_flag = 1'b1;
        end

        case (q.m)
            i2m_pkg::M_IDLE: begin
                if (enable) begin
                    if (cmd.start) begin
                        next_q.m = i2m_pkg::M_START;
                        next_q.step = '0;
                        next_q.ctrl.start = 1'b1;
                        next_q.m_sda = 1'b0;
                        next_q.m_scl = 1'b0;
                    end else if (cmd.rstart) begin
                        next_q.m = i2m_pkg::M_RSTART;
                        next_q.step = '0;
                        next_q.ctrl.rstart = 1'b1;
                        next_q.m_sda = 1'b0;
                    end else if (cmd.stop) begin
                        next_q.m = i2m_pkg::M_STOP;
                        next_q.step = '0;
                        next_q.ctrl.stop = 1'b1;
                        next_q.m_sda = 1'b1;
                    end else if (cmd.ack) begin
                        next_q.m = i2m_pkg::M_ACK;
                        next_q.step = i2m_pkg::STEP_ACK;
                        next_q.ctrl.ack = 1'b1;
                        next_q.chk = 1'b1;
                        next_q.m_sda = ~ack_data;
                    end else if (q.st.transmit_full_flag && q.s != i2m_pkg::S_SEND) begin
                        next_q.m = i2m_pkg::M_TX;
                        next_q.step = '0;
                        next_q.chk = 1'b1;
                        next_q.m_sda = ~q.txb[7];
                    end
                end
            end
            i2m_pkg::M_START: begin
                if (tick) begin
                    if (q.step == '0) begin
                        if (!sda_hi || !scl_hi) begin
                            coll = 1'b1; // R10 R15
                        end else begin
                            next_q.m_sda = 1'b1;
                            next_q.step = 5'h01;
                        end
                    end else begin
                        next_q.m_scl = 1'b1;
                        done = 1'b1;
                    end
                end
            end
            i2m_pkg::M_RSTART: begin
                if (tick) begin
                    if (q.step == '0) begin
                        next_q.m_scl = 1'b0;
                        next_q.step = 5'h01;
                    end else if (q.step == 5'h01) begin
                        if (!sda_hi) begin
                            coll = 1'b1; // R10 R16
                        end else begin
                            next_q.m_sda = 1'b1;
                            next_q.step = 5'h02;
                        end
                    end else begin
                        next_q.m_scl = 1'b1;
                        done = 1'b1;
                    end
                end
            end
            i2m_pkg::M_STOP: begin
                if (tick) begin
                    if (q.step == '0) begin
                        next_q.m_scl = 1'b0;
                        next_q.step = 5'h01;
                    end else if (q.step == 5'h01) begin
                        next_q.m_sda = 1'b0;
                        next_q.step = 5'h02;
                    end else if (!sda_hi || !scl_hi) begin
                        coll = 1'b1; // R10 R17
                    end else begin
                        done = 1'b1;
                    end
                end
            end
            i2m_pkg::M_TX, i2m_pkg::M_ACK: begin
                // even step: clock low half; odd step: clock high half
                if (tick) begin
                    if (!q.step[0]) begin
                        next_q.m_scl = 1'b0;
                        next_q.step = q.step + 1'b1;
                    end else if (q.chk && !q.m_sda && !sda_hi) begin
                        coll = 1'b1; // R07 R10 R26
                    end else if (q.step[4:1] == i2m_pkg::BIT_ACK) begin
                        if (q.m == i2m_pkg::M_TX) begin
                            next_q.st.ack_status = sda_hi;
                            next_q.st.transmit_full_flag = 1'b0;
                        end
                        next_q.m_scl = 1'b1;
                        next_q.m_sda = 1'b0;
                        done = 1'b1;
                    end else begin
                        next_q.m_scl = 1'b1;
                        next_q.txb = {q.txb[6:0], 1'b0};
                        next_q.step = q.step + 1'b1;
                        next_q.chk = q.step[4:1] != i2m_pkg::BIT_DATA7;
                        next_q.m_sda = (q.step[4:1] == i2m_pkg::BIT_DATA7) ? 1'b0 : ~q.txb[6];
                    end
                end
            end
            default: begin
                next_q.m = i2m_pkg::M_IDLE;
            end
        endcase

        // a collision arriving with a software clear still wins
        if (collision_clear) begin
            next_q.st.bus_collision_flag = 1'b0;
        end
        if (coll) begin
            next_q.st.bus_collision_flag = 1'b1; // R08
            next_q.m_irq = 1'b1; // R08
            next_q.m = i2m_pkg::M_IDLE; // R09
            next_q.ctrl = '0; // R12
            next_q.m_scl = 1'b0; // R11 R12
            next_q.m_sda = 1'b0; // R11 R12
            if (q.m == i2m_pkg::M_TX) begin
                next_q.st.transmit_full_flag = 1'b0; // R11
            end
        end
        if (done) begin
            next_q.m = i2m_pkg::M_IDLE;
            next_q.ctrl = '0;
            next_q.m_irq = 1'b1;
        end

        // slave side
        if (q.push && fifo_ready) begin
            next_q.push = 1'b0;
        end
        if (!enable) begin
            next_q.st.start_seen = 1'b0;
            next_q.st.stop_seen = 1'b0;
            next_q.s = i2m_pkg::S_IDLE;
            next_q.s_sda = 1'b0;
            next_q.s_hold = 1'b0;
        end else if (scl_hi && q.scl_p && q.sda_p != sda_hi) begin
            next_q.st.start_seen = !sda_hi; // R19
            next_q.st.stop_seen = sda_hi; // R19
            next_q.s = sda_hi ? i2m_pkg::S_IDLE : i2m_pkg::S_ADDR; // R20
            next_q.sbit = '0;
            next_q.s_sda = 1'b0;
            next_q.s_hold = 1'b0;
            if (sda_hi) begin
                next_q.st.addr10 = 1'b0;
            end
        end else if (q.s != i2m_pkg::S_IDLE) begin
            if (scl_rise) begin
                if (q.sbit < i2m_pkg::BIT_ACK) begin
                    next_q.rsr = {q.rsr[6:0], sda_hi}; // R25
                end else begin
                    next_q.s_nack = sda_hi; // R25
                end
                next_q.sbit = q.sbit + 1'b1;
            end else if (scl_fall) begin
                if (q.sbit == i2m_pkg::BIT_ACK) begin
                    case (q.s)
                        i2m_pkg::S_ADDR: begin
                            next_q.s = i2m_pkg::S_IDLE;
                            if (ten_bit_mode) begin // R21
                                if (q.rsr[7:3] == i2m_pkg::ADDR10_HI && q.rsr[2:1] == own_address[9:8]) begin
                                    if (!q.rsr[0]) begin
                                        next_q.s = i2m_pkg::S_ADDR2;
                                        next_q.s_sda = 1'b1;
                                        next_q.s_irq = 1'b1;
                                    end else if (q.st.addr10) begin
                                        next_q.s = i2m_pkg::S_SEND;
                                        next_q.st.read_sel = 1'b1;
                                        next_q.s_sda = 1'b1;
                                        next_q.s_irq = 1'b1; // R22
                                    end
                                end
                            end else if (q.rsr[7:1] == own_address[6:0]) begin // R21
                                next_q.s = q.rsr[0] ? i2m_pkg::S_SEND : i2m_pkg::S_RECV;
                                next_q.st.read_sel = q.rsr[0];
                                next_q.s_sda = 1'b1;
                                next_q.s_irq = 1'b1; // R22
                            end
                        end
                        i2m_pkg::S_ADDR2: begin
                            if (q.rsr == own_address[7:0]) begin
                                next_q.s = i2m_pkg::S_RECV;
                                next_q.st.addr10 = 1'b1;
                                next_q.st.read_sel = 1'b0;
                                next_q.s_sda = 1'b1;
                                next_q.s_irq = 1'b1; // R22
                            end else begin
                                next_q.s = i2m_pkg::S_IDLE;
                            end
                        end
                        i2m_pkg::S_RECV: begin
                            next_q.push = 1'b1; // R23
                            next_q.pdat = q.rsr; // R23
                            next_q.s_sda = 1'b1; // R23
                            next_q.s_irq = 1'b1; // R23
                        end
                        default: begin
                            next_q.s_sda = 1'b0;
                        end
                    endcase
                end else if (q.sbit > i2m_pkg::BIT_ACK) begin
                    next_q.s_sda = 1'b0;
                    next_q.sbit = '0;
                    if (q.s == i2m_pkg::S_SEND) begin
                        if (q.s_nack) begin
                            next_q.s = i2m_pkg::S_IDLE;
                        end else begin
                            next_q.s_hold = 1'b1;
                        end
                    end
                end else if (q.s == i2m_pkg::S_SEND && q.sbit != '0) begin
                    next_q.s_sda = ~q.sdx[6];
                    next_q.sdx = {q.sdx[6:0], 1'b0};
                end
            end
            // clock held low until software supplies the reply byte
            if (q.s_hold && q.st.transmit_full_flag) begin
                next_q.sdx = q.txb;
                next_q.st.transmit_full_flag = 1'b0;
                next_q.s_sda = ~q.txb[7];
                next_q.s_hold = 1'b0;
            end
        end

        // a full receive buffer stretches the clock rather than losing a byte
        next_q.scl_oe = next_q.m_scl | next_q.s_hold | (next_q.push & ~fifo_ready); // R26
        next_q.sda_oe = next_q.m_sda | next_q.s_sda; // R26
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            q <= i2m_pkg::TOP_RESET;
        end else begin
            q <= next_q;
        end
    end

    i2m_fifo #(
        .WIDTH (i2m_pkg::DATA_W),
        .DEPTH (i2m_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_valid  (q.push),
        .in_data   (q.pdat),
        .in_ready  (fifo_ready),
        .out_valid (rx_valid),
        .out_data  (rx_data),
        .out_ready (rx_ready)
    );
endmodule // i2m_top

// File: shared/i2m_pkg.sv
// shared types and constants of the two-wire multi-master controller
// assumes a single 25 MHz core clock; two core clocks make one instruction cycle
package i2m_pkg;

    localparam int          BAUD_W     = 9;
    localparam int          DATA_W     = 8;
    localparam int          FIFO_DEPTH = 32;
    localparam logic [3:0]  BIT_DATA7  = 4'h7;
    localparam logic [3:0]  BIT_ACK    = 4'h8;
    localparam logic [4:0]  STEP_ACK   = 5'h10;
    localparam logic [4:0]  ADDR10_HI  = 5'h1E;

    // status word bit positions
    localparam int          STAT_TBF   = 0;
    localparam int          STAT_RSEL  = 2;
    localparam int          STAT_START = 3;
    localparam int          STAT_STOP  = 4;
    localparam int          STAT_A10   = 8;
    localparam int          STAT_BCL   = 10;
    localparam int          STAT_ACKST = 15;

    typedef enum logic [5:0] {
        M_IDLE   = 6'h01,
        M_START  = 6'h02,
        M_RSTART = 6'h04,
        M_STOP   = 6'h08,
        M_TX     = 6'h10,
        M_ACK    = 6'h20
    } i2m_mstate_t;

    typedef enum logic [4:0] {
        S_IDLE  = 5'h01,
        S_ADDR  = 5'h02,
        S_ADDR2 = 5'h04,
        S_RECV  = 5'h08,
        S_SEND  = 5'h10
    } i2m_sstate_t;

    typedef struct packed {
        logic start;
        logic rstart;
        logic stop;
        logic ack;
    } i2m_ctrl_t;

    typedef struct packed {
        logic bus_collision_flag;
        logic transmit_full_flag;
        logic start_seen;
        logic stop_seen;
        logic ack_status;
        logic addr10;
        logic read_sel;
    } i2m_status_t;

    typedef struct packed {
        logic              scl_s1;
        logic              scl_s2;
        logic              scl_p;
        logic              sda_s1;
        logic              sda_s2;
        logic              sda_p;
        logic              tcy;
        logic              hold_hi;
        logic [BAUD_W-1:0] baud;
        i2m_mstate_t       m;
        logic [4:0]        step;
        logic              chk;
        logic              m_scl;
        logic              m_sda;
        logic [7:0]        txb;
        i2m_ctrl_t         ctrl;
        i2m_status_t       st;
        logic              m_irq;
        logic              s_irq;
        i2m_sstate_t       s;
        logic [3:0]        sbit;
        logic [7:0]        rsr;
        logic [7:0]        sdx;
        logic              s_sda;
        logic              s_hold;
        logic              s_nack;
        logic              push;
        logic [7:0]        pdat;
        logic              scl_oe;
        logic              sda_oe;
    } i2m_top_state_t;

    localparam i2m_top_state_t TOP_RESET = '{m: M_IDLE, s: S_IDLE, default: '0};

endpackage

// File: testbench/i2m_bus_model.sv
// other masters and slaves on the shared two-wire bus
// assumes pull-ups: a line nobody pulls low reads high
`timescale 1ns/100ps
module i2m_bus_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic ext_scl_low,
    input  wire logic ext_sda_low,
    output logic      scl,
    output logic      sda
);
    // wired-and: stretching and arbitration both come from any party pulling low
    assign scl = !(scl_oe || ext_scl_low);
    assign sda = !(sda_oe || ext_sda_low);
endmodule // i2m_bus_model

// File: testbench/i2m_sva.sv
// port checks on the two-wire controller top
// assumes bind to i2m_top; rst async, active high
`timescale 1ns/100ps
module i2m_sva (
    input wire logic               ref_clk,
    input wire logic               rst,
    input wire logic               enable,
    input wire i2m_pkg::i2m_ctrl_t bus_control_register,
    input wire logic [15:0]        bus_status_register,
    input wire logic               scl_out,
    input wire logic               scl_oe,
    input wire logic               sda_out,
    input wire logic               sda_oe,
    input wire logic               master_irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    a_coll_irq: assert property ($rose(bus_status_register[10]) |-> master_irq)
        else $error("collision without irq");
    a_coll_free: assert property ($rose(bus_status_register[10]) |-> !scl_oe && !sda_oe)
        else $error("lines held after collision");
    a_coll_abort: assert property ($rose(bus_status_register[10]) |-> bus_control_register == 4'h0)
        else $error("request kept after collision");
    a_coll_full: assert property ($rose(bus_status_register[10]) |-> !bus_status_register[0])
        else $error("full flag kept after collision");
    a_irq_pulse: assert property (master_irq |=> !master_irq)
        else $error("irq too long");
    a_open_drain: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    a_seen_excl: assert property (!(bus_status_register[3] && bus_status_register[4]))
        else $error("start and stop seen together");
    a_off_clear: assert property (!enable |=> bus_status_register[4:3] == 2'b00)
        else $error("seen flags kept while off");
endmodule // i2m_sva

bind i2m_top i2m_sva u_sva (.ref_clk, .rst, .enable, .bus_control_register, .bus_status_register,
    .scl_out, .scl_oe, .sda_out, .sda_oe, .master_irq);

// File: testbench/tb_top.sv
// bench: master events, stretch, collisions, slave receive
// assumes package, design, bus model and checker compiled first
`timescale 1ns/100ps
module tb_top;
    logic               ref_clk = 0;
    logic               rst = 1;
    logic               enable = 1;
    i2m_pkg::i2m_ctrl_t cmd = '0;
    logic               wr = 0;
    logic [7:0]         txd = 8'h00;
    logic               clr = 0;
    logic               rdy = 0;
    logic               xscl = 0;
    logic               xsda = 0;
    logic               sirq = 0;
    logic               scl, sda, scl_oe, sda_oe, m_irq, s_irq, rxv, a, got;
    logic [7:0]         rxd;
    logic [15:0]        st;
    i2m_pkg::i2m_ctrl_t ctl;
    int                 error_cnt = 0;
    int                 num_checks = 0;
    int                 n;

    i2m_top u_dut (.ref_clk(ref_clk), .rst(rst), .enable(enable), .ten_bit_mode(1'b0),
        .own_address(10'h03A), .baud_reload_value(9'h003), .cmd(cmd), .ack_data(1'b0),
        .tx_write(wr), .tx_data(txd), .collision_clear(clr), .scl_in(scl), .sda_in(sda),
        .scl_out(), .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .bus_control_register(ctl),
        .bus_status_register(st), .master_irq(m_irq), .slave_irq(s_irq), .rx_valid(rxv),
        .rx_data(rxd), .rx_ready(rdy));
    i2m_bus_model u_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .ext_scl_low(xscl), .ext_sda_low(xsda),
        .scl(scl), .sda(sda));

    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (s_irq === 1'b1) sirq <= 1'b1;

    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic req(input logic [3:0] c, input logic w);
        cmd = c;
        wr = w;
        tick(1);
        cmd = '0;
        wr = 0;
        n = 0;
        while (m_irq !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
    endtask
    // far master: 8 clocks a bit gives the 320 ns link period
    task automatic bb_byte(input logic [7:0] d);
        for (int i = 8; i >= 0; i--) begin
            xsda = (i > 0) ? !d[i-1] : 1'b0;
            tick(2);
            xscl = 0;
            tick(3);
            a = sda;
            tick(1);
            xscl = 1;
            tick(2);
        end
    endtask
    task automatic t_master;
        req(4'h8, 0);
        tick(4);
        check({ctl, st[10], st[3], scl_oe, sda_oe}, 8'h07);
        for (int s = 0; s <= 100; s += 100) begin
            txd = 8'hC5;
            xscl = (s != 0);
            fork
                req(4'h0, 1);
                begin tick(s); xscl = 0; end
            join
            check(n >= 92 + s && n <= 120 + s, 1);
            check({st[15], st[10], st[0]}, 3'b100);
        end
        req(4'h2, 0);
        tick(4);
        check({st[4:3], scl_oe, sda_oe}, 4'h8);
        $display("test master done");
    endtask
    task automatic t_coll;
        check(st[4], 1);
        xsda = 1;
        tick(4);
        req(4'h8, 0);
        check({st[10], ctl, scl_oe, sda_oe}, 7'h40);
        xsda = 0;
        clr = 1;
        tick(1);
        clr = 0;
        tick(4);
        check(st[10], 0);
        req(4'h8, 0);
        txd = 8'hFF;
        xsda = 1;
        req(4'h0, 1);
        check({st[10], st[0], ctl, scl_oe, sda_oe}, 8'h80);
        xsda = 0;
        tick(8);
        $display("test collision done");
    endtask
    task automatic t_slave;
        xsda = 1;
        tick(4);
        xscl = 1;
        tick(2);
        bb_byte({7'h3A, 1'b0});
        check({a, sirq}, 2'b01);
        bb_byte(8'hA5);
        check(a, 0);
        xsda = 1;
        tick(2);
        xscl = 0;
        tick(4);
        xsda = 0;
        tick(4);
        check(st[4:3], 2'b10);
        got = 0;
        rdy = 1;
        repeat (2) begin
            if (rxv === 1'b1 && rxd === 8'hA5) got = 1;
            tick(1);
        end
        check({got, rxv}, 2'b10);
        enable = 0;
        tick(2);
        check(st[4:3], 2'b00);
        enable = 1;
        $display("test slave done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #400000;
        error_cnt++;
        print_verdict;
    end
    initial begin
        tick(16);
        rst = 0;
        tick(4);
        check(st, 16'h0000);
        t_master;
        t_coll;
        t_slave;
        print_verdict;
    end
endmodule // tb_top
